// *** logic/periph_disable_pkg.sv ***
// Purpose: Shared constants and types for the peripheral disable bank
// Assumes: APB register access, one 10 MHz clock
// Notes:   Register offsets are byte addresses, one aligned word each
package periph_disable_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CTL_W    = 8;
  localparam int unsigned NUM_REGS = 5;
  localparam int unsigned IDX_W    = 3;
  localparam int unsigned UNIT_W   = 6;
  localparam int unsigned NUM_BITS = NUM_REGS * CTL_W;

  localparam logic [ADDR_W-1:0] OFF_CORE_SUPPORT_DISABLE     = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_TIMER_OSCILLATOR_DISABLE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_ANALOG_UNIT_DISABLE      = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_WAVEFORM_UNIT_DISABLE    = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_SERIAL_UNIT_DISABLE      = 12'h010;

  localparam logic [IDX_W-1:0] IDX_CORE    = 3'h0;
  localparam logic [IDX_W-1:0] IDX_TIMER   = 3'h1;
  localparam logic [IDX_W-1:0] IDX_ANALOG  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_WAVE    = 3'h3;
  localparam logic [IDX_W-1:0] IDX_SERIAL  = 3'h4;
  localparam logic [IDX_W-1:0] IDX_NONE    = 3'h7;

  // Implemented bits of each register
  localparam logic [CTL_W-1:0] MASK_CORE   = 8'hC7;
  localparam logic [CTL_W-1:0] MASK_TIMER  = 8'h87;
  localparam logic [CTL_W-1:0] MASK_ANALOG = 8'h67;
  localparam logic [CTL_W-1:0] MASK_WAVE   = 8'h3F;
  localparam logic [CTL_W-1:0] MASK_SERIAL = 8'hD1;
  localparam logic [NUM_BITS-1:0] IMPL_MASK =
    {MASK_SERIAL, MASK_WAVE, MASK_ANALOG, MASK_TIMER, MASK_CORE};

  localparam logic [CTL_W-1:0]  CTL_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_ZERO  = 32'h0000_0000;
  localparam logic [CTL_W-1:0]  BYTE_ZERO   = 8'h00;

  // Bit positions inside the core support register
  localparam int unsigned BIT_CLOCK_NET = 7;
  localparam int unsigned BIT_VREF      = 6;
  localparam int unsigned BIT_NVM       = 2;
  localparam int unsigned BIT_REFCLK    = 1;
  localparam int unsigned BIT_PINCHG    = 0;
  // Unit number of a bit is register index times eight plus bit
  localparam int unsigned NVM_UNIT      = BIT_NVM;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned NVM_SETTLE_NS   = 1000;
  localparam int unsigned INSTR_CYCLE_NS  = 400;
  localparam int unsigned NVM_SETTLE_CYC  =
    (NVM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UNIT_SETTLE_CYC =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [UNIT_W-1:0] unit;
  } sfr_req_t;

  typedef struct packed {
    logic periph_clock_net_off;
    logic voltage_ref_off;
    logic nonvolatile_unit_off;
    logic ref_clock_out_off;
    logic pin_change_irq_off;
    logic numeric_osc_off;
    logic limit_timer_off;
    logic gated_timer_off;
    logic basic_timer_off;
    logic dig_to_analog_off;
    logic analog_to_dig_off;
    logic comparator_b_off;
    logic comparator_a_off;
    logic zero_cross_off;
    logic modulator_d_off;
    logic modulator_c_off;
    logic modulator_b_off;
    logic modulator_a_off;
    logic capture_unit_b_off;
    logic capture_unit_a_off;
    logic serial_xcvr_b_off;
    logic serial_xcvr_a_off;
    logic sync_serial_off;
    logic complementary_wave_off;
  } off_flags_t;

endpackage

// *** logic/unit_settle.sv ***
// Purpose: Ready flag for one peripheral after it leaves the disabled state
// Assumes: off comes from a register in the same clock domain
// Notes:   Ready drops one edge after off rises and rises SETTLE_CYC edges after off falls
`timescale 1ns/1ps
module unit_settle #(
  parameter int unsigned SETTLE_CYC = 1
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic off,
  output logic      ready
);

  localparam int unsigned CNT_W = $clog2(SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= CNT_LOAD;
    end else if (off) begin
      count_reg <= CNT_LOAD;
    end else if (count_reg != CNT_ZERO) begin
      count_reg <= count_reg - CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
    end else begin
      ready <= !off && (count_reg <= CNT_ONE);
    end
  end

endmodule

// *** logic/periph_disable_bank.sv ***
// Purpose: Five peripheral disable registers behind an APB slave, with the
//          gating each disable bit applies to its peripheral
// Assumes: Core side requests are synchronous to pclk
// Notes:   APB answers with one wait-free access phase; unmapped reads error
`timescale 1ns/1ps

module periph_disable_bank
  import periph_disable_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core access to peripheral registers
  input  wire sfr_req_t          sfr_req,
  input  wire logic [CTL_W-1:0]  sfr_periph_rdata,
  output logic                   sfr_wr_ok,
  output logic      [CTL_W-1:0]  sfr_rdata,
  // Core access to nonvolatile memory
  input  wire logic              nvm_user_req,
  input  wire logic [CTL_W-1:0]  ptr_mem_rdata,
  output logic                   nvm_user_ok,
  output logic      [CTL_W-1:0]  ptr_rdata,
  // Peripheral controls
  output off_flags_t             unit_off,
  output logic                   periph_clk_en,
  output logic      [NUM_BITS-1:0] unit_hold_reset,
  output logic      [NUM_BITS-1:0] pin_route_off,
  output logic      [NUM_BITS-1:0] unit_ready,
  output logic                   nvm_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = IDX_NONE;
    unique case (addr)
      OFF_CORE_SUPPORT_DISABLE:     idx = IDX_CORE;
      OFF_TIMER_OSCILLATOR_DISABLE: idx = IDX_TIMER;
      OFF_ANALOG_UNIT_DISABLE:      idx = IDX_ANALOG;
      OFF_WAVEFORM_UNIT_DISABLE:    idx = IDX_WAVE;
      OFF_SERIAL_UNIT_DISABLE:      idx = IDX_SERIAL;
      default:                      idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  function automatic logic [CTL_W-1:0] reg_mask(input logic [IDX_W-1:0] idx);
    logic [CTL_W-1:0] m;
    m = BYTE_ZERO;
    unique case (idx)
      IDX_CORE:   m = MASK_CORE;
      IDX_TIMER:  m = MASK_TIMER;
      IDX_ANALOG: m = MASK_ANALOG;
      IDX_WAVE:   m = MASK_WAVE;
      IDX_SERIAL: m = MASK_SERIAL;
      default:    m = BYTE_ZERO;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [CTL_W-1:0]    ctl_reg [NUM_REGS];
  logic [NUM_BITS-1:0] off_flat;
  logic [IDX_W-1:0]    setup_idx;
  logic [IDX_W-1:0]    access_idx_reg;
  logic                write_fire;
  apb_state_t          state_reg;
  apb_state_t          state_next;

  assign setup_idx  = reg_index(paddr);
  assign write_fire = (state_reg == ST_ACCESS) && psel && penable && pwrite
                      && pstrb[0] && (access_idx_reg != IDX_NONE);

  // Only implemented bits store; the rest stay zero
  generate
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_ctl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_reg[r] <= CTL_RESET;
        end else if (write_fire && (access_idx_reg == IDX_W'(r))) begin
          ctl_reg[r] <= pwdata[CTL_W-1:0] & reg_mask(IDX_W'(r));
        end
      end
      assign off_flat[r*CTL_W +: CTL_W] = ctl_reg[r];
    end
  endgenerate

  // The clock network enable is kept as its own flop so it stays glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= 1'b1;
    end else if (write_fire && (access_idx_reg == IDX_CORE)) begin
      periph_clk_en <= !pwdata[BIT_CLOCK_NET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   if (psel && !penable) state_next = ST_ACCESS;
      ST_ACCESS: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_idx_reg <= IDX_NONE;
    end else if (state_reg == ST_IDLE && psel && !penable) begin
      access_idx_reg <= setup_idx;
    end
  end

  // Answer is set up at the setup edge and stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= (state_next == ST_ACCESS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (state_next == ST_ACCESS) begin
      pslverr <= (setup_idx == IDX_NONE);
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_ZERO;
    end else if (state_next == ST_ACCESS && !pwrite && setup_idx != IDX_NONE) begin
      prdata <= {{(DATA_W-CTL_W){1'b0}}, ctl_reg[setup_idx]};
    end else begin
      prdata <= RDATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Named disable flags

  assign unit_off.periph_clock_net_off   = ctl_reg[IDX_CORE][BIT_CLOCK_NET];
  assign unit_off.voltage_ref_off        = ctl_reg[IDX_CORE][BIT_VREF];
  assign unit_off.nonvolatile_unit_off   = ctl_reg[IDX_CORE][BIT_NVM];
  assign unit_off.ref_clock_out_off      = ctl_reg[IDX_CORE][BIT_REFCLK];
  assign unit_off.pin_change_irq_off     = ctl_reg[IDX_CORE][BIT_PINCHG];
  assign unit_off.numeric_osc_off        = ctl_reg[IDX_TIMER][7];
  assign unit_off.limit_timer_off        = ctl_reg[IDX_TIMER][2];
  assign unit_off.gated_timer_off        = ctl_reg[IDX_TIMER][1];
  assign unit_off.basic_timer_off        = ctl_reg[IDX_TIMER][0];
  assign unit_off.dig_to_analog_off      = ctl_reg[IDX_ANALOG][6];
  assign unit_off.analog_to_dig_off      = ctl_reg[IDX_ANALOG][5];
  assign unit_off.comparator_b_off       = ctl_reg[IDX_ANALOG][2];
  assign unit_off.comparator_a_off       = ctl_reg[IDX_ANALOG][1];
  assign unit_off.zero_cross_off         = ctl_reg[IDX_ANALOG][0];
  assign unit_off.modulator_d_off        = ctl_reg[IDX_WAVE][5];
  assign unit_off.modulator_c_off        = ctl_reg[IDX_WAVE][4];
  assign unit_off.modulator_b_off        = ctl_reg[IDX_WAVE][3];
  assign unit_off.modulator_a_off        = ctl_reg[IDX_WAVE][2];
  assign unit_off.capture_unit_b_off     = ctl_reg[IDX_WAVE][1];
  assign unit_off.capture_unit_a_off     = ctl_reg[IDX_WAVE][0];
  assign unit_off.serial_xcvr_b_off      = ctl_reg[IDX_SERIAL][7];
  assign unit_off.serial_xcvr_a_off      = ctl_reg[IDX_SERIAL][6];
  assign unit_off.sync_serial_off        = ctl_reg[IDX_SERIAL][4];
  assign unit_off.complementary_wave_off = ctl_reg[IDX_SERIAL][0];

  // Each unit follows only its own bit
  assign unit_hold_reset = off_flat;
  assign pin_route_off   = off_flat;

  ////////////////////////////////////////////////////////////////////////////
  // Settle timers after re-enable

  generate
    for (genvar u = 0; u < NUM_BITS; u++) begin : g_settle
      if (IMPL_MASK[u]) begin : g_impl
        unit_settle #(
          .SETTLE_CYC ((u == NVM_UNIT) ? NVM_SETTLE_CYC : UNIT_SETTLE_CYC)
        ) u_settle (
          .pclk    (pclk),
          .presetn (presetn),
          .off     (off_flat[u]),
          .ready   (unit_ready[u])
        );
      end else begin : g_none
        assign unit_ready[u] = 1'b0;
      end
    end
  endgenerate

  // Memory ready flag waits out its settle time; nvm_user_ok and ptr_rdata follow the disable bit alone
  assign nvm_ready = unit_ready[NVM_UNIT];

  ////////////////////////////////////////////////////////////////////////////
  // Access gating toward peripherals

  // Out-of-range or unimplemented unit numbers count as disabled
  function automatic logic unit_blocked(input logic [UNIT_W-1:0] unit);
    logic blocked;
    blocked = 1'b1;
    if (unit < UNIT_W'(NUM_BITS)) begin
      blocked = off_flat[unit] || !IMPL_MASK[unit];
    end
    return blocked;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfr_wr_ok <= 1'b0;
    end else begin
      // Memory-controller registers belong to the memory unit number
      sfr_wr_ok <= sfr_req.valid && sfr_req.write
                   && !unit_blocked(sfr_req.unit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfr_rdata <= BYTE_ZERO;
    end else if (sfr_req.valid && !sfr_req.write && !unit_blocked(sfr_req.unit)) begin
      sfr_rdata <= sfr_periph_rdata;
    end else begin
      sfr_rdata <= BYTE_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_user_ok <= 1'b0;
    end else begin
      nvm_user_ok <= nvm_user_req && !off_flat[NVM_UNIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_rdata <= BYTE_ZERO;
    end else if (off_flat[NVM_UNIT]) begin
      ptr_rdata <= BYTE_ZERO;
    end else begin
      ptr_rdata <= ptr_mem_rdata;
    end
  end

endmodule

// *** tb/periph_disable_checker.sv ***
// Purpose: Port-level assertions for the peripheral disable bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/1ps
module periph_disable_checker
  import periph_disable_pkg::*;
(
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [DATA_W-1:0]   prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Core side
  input wire sfr_req_t            sfr_req,
  input wire logic                sfr_wr_ok,
  input wire logic                nvm_user_req,
  input wire logic                nvm_user_ok,
  input wire logic [CTL_W-1:0]    ptr_rdata,
  // Peripheral controls
  input wire off_flags_t          unit_off,
  input wire logic                periph_clk_en,
  input wire logic [NUM_BITS-1:0] unit_hold_reset,
  input wire logic [NUM_BITS-1:0] pin_route_off,
  input wire logic [NUM_BITS-1:0] unit_ready,
  input wire logic                nvm_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire logic nvm_off = unit_off.nonvolatile_unit_off;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_nvm_ctl_write;
    sfr_req.valid && sfr_req.write && (sfr_req.unit == 6'(NVM_UNIT)) && nvm_off;
  endsequence

  a_setup_answer: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_in_access: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_rdata_low_byte: assert property (prdata[31:8] == 24'h0)
    else $error("upper read data set");
  a_clk_net_gate: assert property (periph_clk_en == !unit_off.periph_clock_net_off)
    else $error("clock network enable wrong");
  a_route_follows_hold: assert property ((pin_route_off == unit_hold_reset) &&
    (unit_hold_reset[2] == nvm_off)) else $error("routing or hold mismatch");
  a_unimpl_idle: assert property (((unit_ready | unit_hold_reset) & ~IMPL_MASK) == '0)
    else $error("unimplemented position active");
  a_nvm_block: assert property (nvm_user_req && nvm_off |=> !nvm_user_ok)
    else $error("memory access while off");
  a_nvm_allow: assert property (nvm_user_req && !nvm_off |=> nvm_user_ok)
    else $error("memory access refused");
  a_ptr_zero: assert property (nvm_off |=> ptr_rdata == BYTE_ZERO)
    else $error("pointer read not zero");
  a_ctl_write_block: assert property (s_nvm_ctl_write |=> !sfr_wr_ok)
    else $error("controller write allowed");
  a_ready_drop: assert property ($rose(nvm_off) |=> !nvm_ready)
    else $error("memory ready kept");
  a_ready_settle: assert property ($rose(nvm_ready) |-> !$past(nvm_off, 9) && !nvm_off)
    else $error("memory ready too early");
endmodule

bind periph_disable_bank periph_disable_checker i_periph_disable_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sfr_req(sfr_req), .sfr_wr_ok(sfr_wr_ok),
  .nvm_user_req(nvm_user_req), .nvm_user_ok(nvm_user_ok), .ptr_rdata(ptr_rdata),
  .unit_off(unit_off), .periph_clk_en(periph_clk_en), .unit_hold_reset(unit_hold_reset),
  .pin_route_off(pin_route_off), .unit_ready(unit_ready), .nvm_ready(nvm_ready));

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the peripheral disable bank
// Assumes: APB master tasks, core side driven directly
// Notes:   Expected register contents kept in exp_r
`timescale 1ns/1ps
module testbench;
  import periph_disable_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, nvm_user_req;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata, rd_v;
  logic [3:0]          pstrb;
  logic                pready, pslverr, sfr_wr_ok, nvm_user_ok, periph_clk_en;
  logic                nvm_ready, err_v;
  sfr_req_t            sfr_req;
  logic [CTL_W-1:0]    sfr_rdata, ptr_rdata, periph_rd, mem_rd;
  off_flags_t          unit_off;
  logic [NUM_BITS-1:0] unit_hold_reset, pin_route_off, unit_ready, flat;
  logic [CTL_W-1:0]    exp_r [5];
  int                  errors, tests_run, n;

  assign flat = {exp_r[4], exp_r[3], exp_r[2], exp_r[1], exp_r[0]};

  periph_disable_bank i_periph_disable_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sfr_req(sfr_req), .sfr_periph_rdata(periph_rd),
    .sfr_wr_ok(sfr_wr_ok), .sfr_rdata(sfr_rdata), .nvm_user_req(nvm_user_req),
    .ptr_mem_rdata(mem_rd), .nvm_user_ok(nvm_user_ok), .ptr_rdata(ptr_rdata),
    .unit_off(unit_off), .periph_clk_en(periph_clk_en), .unit_hold_reset(unit_hold_reset),
    .pin_route_off(pin_route_off), .unit_ready(unit_ready), .nvm_ready(nvm_ready));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      errors++;
      end_sim();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, ADDR_W'(i * 4), d, 4'hF);
    chk(40'(err_v), 40'h0);
    exp_r[i] = d & IMPL_MASK[i*8 +: 8];
  endtask

  task automatic rdchk(input int i);
    apb(1'b0, ADDR_W'(i * 4), 8'h00, 4'h0);
    chk(40'(rd_v), 40'(exp_r[i]));
  endtask

  task automatic chk_outs;
    @(posedge pclk);
    chk(unit_hold_reset, flat);
    chk(pin_route_off, flat);
    chk(40'(periph_clk_en), 40'(!flat[7]));
    chk(40'(unit_off), 40'({flat[7:6], flat[2:0], flat[15], flat[10:8], flat[22:21],
      flat[18:16], flat[29:24], flat[39:38], flat[36], flat[32]}));
  endtask

  // Core request to a unit's registers with a memory request alongside
  task automatic core(input logic w, input int u);
    logic en;
    en = (u < NUM_BITS) ? (IMPL_MASK[u] && !flat[u]) : 1'b0;
    @(posedge pclk);
    sfr_req <= {1'b1, w, 6'(u)};
    nvm_user_req <= 1'b1;
    periph_rd <= 8'(u) ^ 8'h5A;
    mem_rd <= 8'(u) ^ 8'hA5;
    @(posedge pclk);
    sfr_req <= '0;
    nvm_user_req <= 1'b0;
    @(posedge pclk);
    chk(40'(sfr_wr_ok), 40'(w & en));
    chk(40'(sfr_rdata), (!w && en) ? 40'(8'(u) ^ 8'h5A) : 40'h0);
    chk(40'(nvm_user_ok), 40'(!flat[2]));
    chk(40'(ptr_rdata), flat[2] ? 40'h0 : 40'(8'(u) ^ 8'hA5));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    tests_run = 0;
    {psel, penable, pwrite, nvm_user_req, paddr, pwdata, pstrb} = '0;
    sfr_req = '0;
    periph_rd = 8'h00;
    mem_rd = 8'h00;
    for (int i = 0; i < 5; i++) exp_r[i] = CTL_RESET;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdchk(i);
    chk_outs();
    for (int i = 0; i < 5; i++) begin
      wr(i, 8'hFF);
      rdchk(i);
    end
    chk_outs();
    chk(unit_ready, 40'h0);
    for (int u = 0; u < 64; u++) begin
      core(1'b1, u);
      core(1'b0, u);
    end
    // Ignored lane, unmapped place, then release everything
    apb(1'b1, 12'h000, 8'h00, 4'h0);
    chk(40'(err_v), 40'h0);
    apb(1'b1, 12'h014, 8'h00, 4'hF);
    chk(40'(err_v), 40'h1);
    apb(1'b0, 12'h014, 8'h00, 4'h0);
    chk(40'(err_v), 40'h1);
    chk(40'(rd_v), 40'h0);
    rdchk(0);
    for (int i = 0; i < 5; i++) wr(i, 8'h00);
    n = 0;
    while (unit_ready !== IMPL_MASK && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(unit_ready, IMPL_MASK);
    for (int u = 0; u < 64; u++) core(1'b1, u);
    // Memory off with three timer units, core neighbours untouched, then restart delay
    wr(1, 8'h85);
    wr(0, 8'h04);
    chk_outs();
    core(1'b1, NVM_UNIT);
    core(1'b0, 8);
    wr(0, 8'h00);
    n = 0;
    while (nvm_ready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(40'(n >= NVM_SETTLE_CYC - 1 && n <= NVM_SETTLE_CYC + 2), 40'h1);
    // Second reset clears every control bit
    wr(3, 8'h3F);
    wr(0, 8'hC7);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) exp_r[i] = CTL_RESET;
    for (int i = 0; i < 5; i++) rdchk(i);
    chk_outs();
    end_sim();
  end
endmodule
